// ---- bench/acu_checker.sv ----
// checker of the uart core ports: bus answers and transmit line shape
// assumes a bind onto acu_uart_core, single clock domain
`timescale 1ns/1ps
module acu_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic awready,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic txOut,
  input wire logic txDoneIrq,
  input wire logic rxDoneIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // answers stand until taken, new requests refused meanwhile
  a_bresp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer changed before taken");
  a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer changed before taken");
  a_write_refused: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  a_read_upper: assert property (rvalid |-> !arready && rdata[31:8] == 24'h000000)
    else $error("read answer malformed");
  // done requests are single-cycle pulses
  a_txdone_pulse: assert property (txDoneIrq |=> !txDoneIrq)
    else $error("transmit done longer than one cycle");
  a_rxdone_pulse: assert property (rxDoneIrq |=> !rxDoneIrq)
    else $error("receive done longer than one cycle");
  // a low level on the line lasts at least eight clocks
  a_start_width: assert property ($fell(txOut) |-> !txOut [*8])
    else $error("low bit too short");
  a_stop_high: assert property (txDoneIrq |-> txOut && $past(txOut))
    else $error("frame ended without high stop");
  c_tx: cover property (txDoneIrq);
  c_rx: cover property (rxDoneIrq);
  c_slverr: cover property (bvalid && bresp == 2'h2);
endmodule

// ---- bench/acu_peer.sv ----
// remote serial peer: sends frames on the receive line, captures transmit frames
// assumes bitClk and capLen are set by the bench before each frame
`timescale 1ns/1ps
module acu_peer (
  input wire logic clk,
  input wire logic txOut,
  output logic rxLine
);
  int bitClk = 32;
  int capLen = 10;
  int capCnt = 0;
  logic [11:0] capFrm;
  initial rxLine = 1'b1;
  always begin
    @(negedge txOut);
    repeat (bitClk / 2) @(posedge clk);
    for (int k = 0; k < capLen; k++) begin
      capFrm[k] = txOut;
      if (k < capLen - 1) repeat (bitClk) @(posedge clk);
    end
    capCnt++;
  end
  // bits lsb first, line back to idle high after
  task automatic send(input logic [11:0] f, input int n);
    @(posedge clk);
    for (int k = 0; k < n; k++) begin
      rxLine <= f[k];
      repeat (bitClk) @(posedge clk);
    end
    rxLine <= 1'b1;
  endtask
  // low pulse shorter than half a bit
  task automatic glitch();
    @(posedge clk);
    rxLine <= 1'b0;
    repeat (bitClk / 4) @(posedge clk);
    rxLine <= 1'b1;
  endtask
endmodule

// ---- bench/testbench.sv ----
// self-checking bench of the uart core: axi4-lite master, frame model, peer
// assumes acu_pkg compiled first and acu_cfg.svh on the include path
`timescale 1ns/1ps
`include "acu_cfg.svh"
module testbench;
  import acu_pkg::*;
  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, rxIn;
  logic awready, wready, bvalid, arready, rvalid, txOut, txDoneIrq, rxDoneIrq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, extCnt;
  logic [1:0] bresp, rresp;
  int fail_count = 0;
  int comparisons = 0;
  int txN = 0;
  int rxN = 0;
  acu_uart_core acu_uart_core_inst (.clk(clk), .rst_b(rst_b), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rxIn(rxIn), .txOut(txOut), .extBaudClkPin(extCnt[3]),
    .txDoneIrq(txDoneIrq), .rxDoneIrq(rxDoneIrq));
  acu_peer acu_peer_inst (.clk(clk), .txOut(txOut), .rxLine(rxIn));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // done pulse counters, sampled before the edge updates land
  always @(posedge clk) begin
    extCnt <= extCnt + 4'h1;
    if (txDoneIrq === 1'b1) txN++;
    if (rxDoneIrq === 1'b1) rxN++;
  end
  task automatic end_sim();
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // frame model: start, data, parity, stops; bp/bs corrupt parity/first stop
  function automatic logic [11:0] mkf(input logic [7:0] d, input acu_par_t par,
    input logic cl, input logic sl, input logic bp, input logic bs, output int n);
    logic [11:0] f;
    logic p;
    f = 12'hFFF;
    f[0] = 1'b0;
    n = 1;
    for (int k = 0; k < (cl ? 8 : 7); k++) f[n++] = d[k];
    p = ^(d & (cl ? 8'hFF : 8'h7F));
    if (par != ACU_PAR_NONE) f[n++] = bp ^ (par == ACU_PAR_EVEN ? p : par == ACU_PAR_ODD ? ~p : 1'b0);
    f[n] = ~bs;
    n = n + 1 + sl;
    return f;
  endfunction
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic hA, hW, hB;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hB = 1'b0;
    while (!hB) begin
      @(negedge clk);
      hA = awvalid && awready;
      hW = wvalid && wready;
      hB = bvalid;
      r = bresp;
      @(posedge clk);
      if (hA) awvalid <= 1'b0;
      if (hW) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hA, hR;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hR = 1'b0;
    while (!hR) begin
      @(negedge clk);
      hA = arvalid && arready;
      hR = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (hA) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    end_sim();
  end
  initial begin
    logic [31:0] seed;
    logic [31:0] d32;
    logic [7:0] d, b;
    logic [1:0] r;
    logic [11:0] f;
    logic cl, sl, bp, bs, v;
    acu_par_t par;
    int n, t0, r0;
    seed = 32'hC10FDCED;
    rst_b = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    extCnt = 4'h0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 7; a++) rdc(8'(a * 4), 32'h00000000);
    wr(8'h40, 8'h00, r);
    chk(r, `ACU_RESP_SLVERR);
    rd(8'h40, d32, r);
    chk({d32[29:0], r}, `ACU_RESP_SLVERR);
    for (int i = 0; i < 16; i++) begin
      {sl, cl} = 2'(i >> 2);
      par = acu_par_t'(i[1:0]);
      v = i[0];
      // mode rewritten only between frames
      // one pass on the external pin: rise every 16 clocks, tick per 2 rises, 8 ticks a bit
      wr(`ACU_OFF_BAUD, (i == 12) ? {`ACU_BAUD_EXT, 4'h0} : {3'h0, v, 4'h0}, r);
      acu_peer_inst.bitClk = (i == 12) ? 256 : 32 << v;
      wr(`ACU_OFF_MODE, {2'b11, par, cl, sl, 2'b00}, r);
      seed = lfsr(seed);
      {bs, bp, d} = seed[9:0];
      f = mkf(d, par, cl, sl, 1'b0, 1'b0, n);
      acu_peer_inst.capLen = n;
      t0 = txN;
      wr(`ACU_OFF_TXS, d, r);
      for (int t = 0; t < 4000 && txN == t0; t++) @(posedge clk);
      chk(txN, t0 + 1);
      chk(acu_peer_inst.capFrm & ~(12'hFFF << n), f & ~(12'hFFF << n));
      f = mkf(d, par, cl, sl, bp, bs, n);
      r0 = rxN;
      acu_peer_inst.send(f, n);
      chk(rxN, r0 + 1);
      rdc(`ACU_OFF_STAT, {29'h0, bp && par[1], bs, 1'b0});
      rdc(`ACU_OFF_RXB, {24'h0, d & (cl ? 8'hFF : 8'h7F)});
      rdc(`ACU_OFF_STAT, 32'h00000000);
    end
    f = mkf(d, par, cl, sl, 1'b1, 1'b0, n);
    acu_peer_inst.send(f, n);
    b = ~d;
    f = mkf(b, par, cl, sl, 1'b0, 1'b0, n);
    acu_peer_inst.send(f, n);
    rdc(`ACU_OFF_STAT, 32'h00000001);
    rdc(`ACU_OFF_RXB, {24'h0, b});
    f = mkf(d, par, cl, sl, 1'b0, 1'b0, n);
    r0 = rxN;
    fork
      acu_peer_inst.send(f, n);
      begin
        repeat (200) @(posedge clk);
        wr(`ACU_OFF_MODE, {2'b10, par, cl, sl, 2'b00}, r);
      end
    join
    chk(rxN, r0);
    // buffer read after disable: bit-order bit set first
    wr(`ACU_OFF_SYNC, 8'h04, r);
    rdc(`ACU_OFF_SYNC, 32'h00000004);
    rdc(`ACU_OFF_RXB, {24'h0, b});
    wr(`ACU_OFF_MODE, {2'b11, par, cl, sl, 2'b00}, r);
    acu_peer_inst.glitch();
    repeat (300) @(posedge clk);
    chk(rxN, r0);
    acu_peer_inst.send(f, n);
    rdc(`ACU_OFF_RXB, {24'h0, d});
    rdc(`ACU_OFF_FLAG, 32'h00000003);
    wr(`ACU_OFF_FLAG, 8'h03, r);
    rdc(`ACU_OFF_FLAG, 32'h00000000);
    end_sim();
  end
endmodule
bind acu_uart_core acu_checker acu_checker_inst (.clk(clk), .rst_b(rst_b), .awready(awready),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arready(arready),
  .rdata(rdata), .rvalid(rvalid), .rready(rready), .txOut(txOut), .txDoneIrq(txDoneIrq),
  .rxDoneIrq(rxDoneIrq));

// ---- src/acu_cfg.svh ----
// constants of the async serial uart core: offsets, fields, response codes, timing
// assumes inclusion by the package before anything that uses them
`ifndef ACU_CFG_SVH
`define ACU_CFG_SVH
`define ACU_AW 8
`define ACU_OFF_MODE 8'h00
`define ACU_OFF_STAT 8'h04
`define ACU_OFF_BAUD 8'h08
`define ACU_OFF_TXS 8'h0C
`define ACU_OFF_RXB 8'h10
`define ACU_OFF_FLAG 8'h14
`define ACU_OFF_SYNC 8'h18
`define ACU_BAUD_EXT 4'h8
`define ACU_BIT_ORDER_POS 2
`define ACU_RESP_OKAY 2'h0
`define ACU_RESP_SLVERR 2'h2
`define ACU_SUB_LAST 3'h7
`define ACU_SUB_HALF 3'h3
`define ACU_PRE_BASE 10'h004
`endif

// ---- src/acu_pkg.sv ----
// types of the async serial uart core: states, modes and the state record
// assumes acu_cfg.svh sits in the include path
`include "acu_cfg.svh"
package acu_pkg;
  typedef enum logic [1:0] {ACU_TX_IDLE = 2'b01, ACU_TX_SHIFT = 2'b10} acu_tx_st_t;
  typedef enum logic [2:0] {
    ACU_RX_IDLE = 3'b001, ACU_RX_HALF = 3'b010, ACU_RX_DATA = 3'b100
  } acu_rx_st_t;
  typedef enum logic [1:0] {
    ACU_PAR_NONE = 2'b00, ACU_PAR_ZERO = 2'b01, ACU_PAR_ODD = 2'b10, ACU_PAR_EVEN = 2'b11
  } acu_par_t;
  // mode register bits 7..2, bits 1..0 read as zero
  typedef struct packed {
    logic txEn;
    logic rxEn;
    acu_par_t parity;
    logic charLen;
    logic stopLen;
  } acu_mode_t;
  typedef struct packed {
    logic awRdy;
    logic awHave;
    logic [7:0] awAddr;
    logic wRdy;
    logic wHave;
    logic [7:0] wData;
    logic wStb;
    logic bValid;
    logic [1:0] bResp;
    logic arRdy;
    logic rValid;
    logic [7:0] rData;
    logic [1:0] rResp;
    acu_mode_t mode;
    logic [3:0] baudSel;
    logic bitOrder;
    logic [9:0] pre;
    logic extPrev;
    logic extHalf;
    acu_tx_st_t txSt;
    logic [11:0] txSh;
    logic [3:0] txCnt;
    logic [2:0] txSub;
    logic txOut;
    acu_rx_st_t rxSt;
    logic [9:0] rxFr;
    logic [3:0] rxCnt;
    logic [2:0] rxSub;
    logic [7:0] rxBuf;
    logic rxFull;
    logic errPar;
    logic errFrm;
    logic errOvr;
    logic txFlag;
    logic rxFlag;
    logic txIrq;
    logic rxIrq;
  } acu_state_t;
endpackage

// ---- src/acu_uart_core.sv ----
// async serial uart core: transmitter, receiver, baud source, axi4-lite slave
// assumes rxIn and extBaudClkPin are already synchronous to clk
`timescale 1ns/1ps
module acu_uart_core
  import acu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxIn,
  output logic txOut,
  input wire logic extBaudClkPin,
  output logic txDoneIrq,
  output logic rxDoneIrq
);

  acu_state_t s;
  acu_state_t n;
  logic [1:0] rstSync;
  logic rstSyncB;
  logic tick;
  logic preHit;
  logic extRise;
  logic [9:0] preMask;
  logic [3:0] charBits;
  logic parOn;
  logic [3:0] needBits;
  logic [7:0] txChar;
  logic [7:0] rxChar;
  logic rxStop;
  logic rxParBit;

  // expected parity bit of a character for the selected mode
  function automatic logic parOf(input logic [7:0] d, input acu_par_t p);
    logic r;
    r = 1'b0;
    case (p)
      ACU_PAR_EVEN: r = ^d;
      ACU_PAR_ODD: r = ~^d;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // mask bit 7 away when 7-bit characters are chosen
  function automatic logic [7:0] charMask(input logic [7:0] d, input logic len8);
    return len8 ? d : {1'b0, d[6:0]};
  endfunction

  // reset release through two stages, assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstSyncB = rstSync[1];

  always_comb begin
    n = s;
    tick = 1'b0;
    preHit = 1'b0;
    extRise = 1'b0;
    preMask = 10'h000;
    charBits = 4'h0;
    parOn = 1'b0;
    needBits = 4'h0;
    txChar = 8'h00;
    rxChar = 8'h00;
    rxStop = 1'b0;
    rxParBit = 1'b0;
    n.txIrq = 1'b0;
    n.rxIrq = 1'b0;

    // frame shape from the mode register
    // character length select
    charBits = s.mode.charLen ? 4'h8 : 4'h7;
    parOn = (s.mode.parity != ACU_PAR_NONE);
    // one stop bit sampled regardless of stop length
    needBits = charBits + {3'h0, parOn} + 4'h1;

    // baud source; prohibited selections simply give no tick
    // prescale by 2^(n+2), bit counter divides by 8
    preMask = (`ACU_PRE_BASE << s.baudSel[2:0]) - 10'h001;
    preHit = (s.pre == preMask);
    n.pre = preHit ? 10'h000 : s.pre + 10'h001;
    extRise = extBaudClkPin && !s.extPrev;
    n.extPrev = extBaudClkPin;
    if (extRise) begin
      n.extHalf = ~s.extHalf;
    end
    if (s.baudSel == `ACU_BAUD_EXT) begin
      tick = extRise && s.extHalf; // external clock halved, then 8 per bit
    end else if (!s.baudSel[3]) begin
      tick = preHit;
    end

    // bus: write address and data captured independently
    if (awvalid && s.awRdy) begin
      n.awHave = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && s.wRdy) begin
      n.wHave = 1'b1;
      n.wData = wdata[7:0];
      n.wStb = wstrb[0];
    end
    if (s.bValid && bready) begin
      n.bValid = 1'b0;
    end

    // register write once both halves are held
    if (s.awHave && s.wHave && !s.bValid) begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bValid = 1'b1;
      n.bResp = `ACU_RESP_OKAY;
      case (s.awAddr)
        `ACU_OFF_MODE: begin
          if (s.wStb) begin
            n.mode = acu_mode_t'(s.wData[7:2]);
          end
        end
        `ACU_OFF_BAUD: begin
          if (s.wStb) begin
            n.baudSel = s.wData[7:4];
            n.pre = 10'h000;
          end
        end
        `ACU_OFF_TXS: begin
          // load starts a frame; ignored while busy or disabled
          if (s.wStb && s.mode.txEn && s.txSt == ACU_TX_IDLE) begin
            // bit 7 dropped in 7-bit mode
            txChar = charMask(s.wData, s.mode.charLen);
            // start bit goes out now, rest queued in shifter
            n.txSh = 12'hFFF;
            for (int i = 0; i < 8; i++) begin
              if (4'(i) < charBits) begin
                n.txSh[i] = txChar[i];
              end
            end
            if (parOn) begin
              n.txSh[charBits] = parOf(txChar, s.mode.parity);
            end
            // one or two stop bits sent
            // count runs from start bit to last stop, so done waits for the full stop time
            n.txCnt = needBits + {3'h0, s.mode.stopLen} + 4'h1;
            n.txSub = 3'h0;
            n.txOut = 1'b0;
            n.txSt = ACU_TX_SHIFT;
          end
        end
        `ACU_OFF_FLAG: begin
          // write one to clear; events below are applied later and win
          if (s.wStb && s.wData[0]) begin
            n.txFlag = 1'b0;
          end
          if (s.wStb && s.wData[1]) begin
            n.rxFlag = 1'b0;
          end
        end
        `ACU_OFF_SYNC: begin
          if (s.wStb) begin
            n.bitOrder = s.wData[`ACU_BIT_ORDER_POS];
          end
        end
        `ACU_OFF_STAT, `ACU_OFF_RXB: begin
          n.bResp = `ACU_RESP_OKAY; // read-only, write ignored
        end
        default: begin
          n.bResp = `ACU_RESP_SLVERR;
        end
      endcase
    end

    // register read, answered at the same edge that accepts the address
    if (s.rValid && rready) begin
      n.rValid = 1'b0;
    end
    if (arvalid && s.arRdy) begin
      n.rValid = 1'b1;
      n.rResp = `ACU_RESP_OKAY;
      n.rData = 8'h00;
      case (araddr)
        `ACU_OFF_MODE: n.rData = {s.mode, 2'b00};
        `ACU_OFF_STAT: n.rData = {5'h00, s.errPar, s.errFrm, s.errOvr};
        `ACU_OFF_BAUD: n.rData = {s.baudSel, 4'h0};
        `ACU_OFF_TXS: n.rData = 8'h00;
        `ACU_OFF_FLAG: n.rData = {6'h00, s.rxFlag, s.txFlag};
        `ACU_OFF_SYNC: n.rData = {5'h00, s.bitOrder, 2'b00};
        `ACU_OFF_RXB: begin
          n.rData = s.rxBuf;
          // buffer read clears error flags and the full mark
          n.rxFull = 1'b0;
          n.errPar = 1'b0;
          n.errFrm = 1'b0;
          n.errOvr = 1'b0;
        end
        default: n.rResp = `ACU_RESP_SLVERR;
      endcase
    end

    // transmitter: each bit lasts eight ticks
    case (s.txSt)
      ACU_TX_IDLE: begin
        if (n.txSt == ACU_TX_IDLE) begin
          n.txOut = 1'b1;
        end
      end
      ACU_TX_SHIFT: begin
        if (!s.mode.txEn) begin
          n.txSt = ACU_TX_IDLE; // disable abandons the frame, line idles
          n.txOut = 1'b1;
        end else if (tick) begin
          n.txSub = s.txSub + 3'h1;
          if (s.txSub == `ACU_SUB_LAST) begin
            if (s.txCnt == 4'h1) begin
              n.txSt = ACU_TX_IDLE;
              n.txOut = 1'b1;
              n.txIrq = 1'b1;
              n.txFlag = 1'b1;
            end else begin
              n.txCnt = s.txCnt - 4'h1;
              n.txOut = s.txSh[0];
              n.txSh = {1'b1, s.txSh[11:1]};
            end
          end
        end
      end
      default: begin
        n.txSt = ACU_TX_IDLE;
        n.txOut = 1'b1;
      end
    endcase

    // receiver
    case (s.rxSt)
      ACU_RX_IDLE: begin
        // after a frame the line must be seen high first, else a low stop bit restarts
        if (rxIn) begin
          n.rxCnt = 4'h0;
        // sampling only while receive is enabled
        end else if (s.mode.rxEn && s.rxCnt == 4'h0) begin
          n.rxSt = ACU_RX_HALF;
          n.rxSub = 3'h0;
        end
      end
      ACU_RX_HALF: begin
        // resample after half a bit, low confirms start
        if (tick && s.mode.rxEn) begin
          n.rxSub = s.rxSub + 3'h1;
          if (s.rxSub == `ACU_SUB_HALF) begin
            n.rxSt = rxIn ? ACU_RX_IDLE : ACU_RX_DATA;
            n.rxSub = 3'h0;
            n.rxCnt = 4'h0;
          end
        end
      end
      ACU_RX_DATA: begin
        if (tick && s.mode.rxEn) begin
          n.rxSub = s.rxSub + 3'h1;
          if (s.rxSub == `ACU_SUB_LAST) begin
            n.rxFr[s.rxCnt] = rxIn;
            n.rxCnt = s.rxCnt + 4'h1;
            // data, parity, one stop then done
            if (s.rxCnt == needBits - 4'h1) begin
              // bit 7 reads zero in 7-bit mode
              rxChar = charMask(n.rxFr[7:0], s.mode.charLen);
              rxParBit = n.rxFr[charBits];
              rxStop = n.rxFr[needBits - 4'h1];
              // error frames delivered just the same
              n.rxBuf = rxChar;
              n.rxIrq = 1'b1;
              n.rxFlag = 1'b1;
              n.errPar = s.mode.parity[1] && (rxParBit != parOf(rxChar, s.mode.parity));
              n.errFrm = !rxStop;
              n.errOvr = n.rxFull; // a same-cycle buffer read prevents overrun
              n.rxFull = 1'b1;
              n.rxSt = ACU_RX_IDLE;
            end
          end
        end
      end
      default: n.rxSt = ACU_RX_IDLE;
    endcase
    // disable stops reception; frame end is gated off above, so buffer
    // flags and pulse stay as they are while a same-cycle buffer read still clears
    if (!s.mode.rxEn && s.rxSt != ACU_RX_IDLE) begin
      n.rxSt = ACU_RX_IDLE;
      n.rxCnt = 4'h1; // rest of the cut frame must not pass for a start
    end

    // ready flags follow the next occupancy so they are registered
    n.awRdy = !n.awHave && !n.bValid;
    n.wRdy = !n.wHave && !n.bValid;
    n.arRdy = !n.rValid;
  end

  // single state register; the line idles high out of reset
  always_ff @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      s <= '0;
      s.txSt <= ACU_TX_IDLE;
      s.rxSt <= ACU_RX_IDLE;
      s.txOut <= 1'b1;
      s.txSh <= 12'hFFF;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign awready = s.awRdy;
  assign wready = s.wRdy;
  assign bvalid = s.bValid;
  assign bresp = s.bResp;
  assign arready = s.arRdy;
  assign rvalid = s.rValid;
  assign rresp = s.rResp;
  assign rdata = {24'h000000, s.rData};
  assign txOut = s.txOut;
  assign txDoneIrq = s.txIrq;
  assign rxDoneIrq = s.rxIrq;

endmodule
